// >>> core/sfifo_core.sv
// Purpose: buffer with standard and fall-through modes, five flags, offsets
// Assumes: write/read clocks arrive as pins, sampled by clk
// Notes: one write and one read may land in the same clk cycle
// How it works
// - master reset latches two straps to pick standard or fall-through mode, a third for synchronous almost flags
// - standard mode: data reaches outputs only through an explicit read
// - fall-through: first word reaches outputs after three read clock edges
// - word stored on write clock edge while write enable low, not full
// - standard: empty flag high after first write, low when drained, blocks reads
// - standard: almost-empty high at n+1 words, low at n or fewer
// - standard: half-full low above half the depth, high again at half
// - standard: almost-full low at depth minus m words or more
// - default offsets 31, 63 or 127 depending on depth
// - standard: full flag low at depth, blocks writes, first read clears
// - fall-through: output-ready low when word shown, high when drained
// - fall-through: almost-empty high at n+2 words, low at n+1 or fewer
// - fall-through: half-full low one word later than standard
// - fall-through: almost-full low at depth plus one minus m
// - fall-through: capacity depth plus one, input-ready high then
// - fall-through default almost-empty threshold one above standard
// - load select and write enable low store empty then full offset
// - load sequence position kept across normal operation
// - load select and read enable low read empty then full offset
// - offset readback only in standard mode
// - synchronous almost flags move only on their own clock edges or during master reset
`timescale 1ns/1ns
module sfifo_core
  import sfifo_pkg::*;
#(
  parameter int DW = sfifo_pkg::DATA_W_DEF, // data width
  parameter int DEPTH = sfifo_pkg::DEPTH_DEF // memory words
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic write_clk, // write clock pin
  input wire logic read_clk, // read clock pin
  input wire logic write_enable_n, // write enable pin
  input wire logic read_enable_n, // read enable pin
  input wire logic offset_load_select_n, // offset access select
  input wire logic master_reset_n, // reset operation pin
  input wire logic first_device_select_n, // strap
  input wire logic read_expansion_in_n, // strap
  input wire logic write_expansion_in_n, // strap
  input wire logic [DW-1:0] data_in, // write data
  output logic [DW-1:0] data_out, // output register
  output logic empty_flag_n, // empty / output ready
  output logic full_flag_n, // full flag
  output logic input_ready_n, // input ready, same state as full
  output logic half_full_flag_n, // half-full flag
  output logic almost_empty_flag_n, // almost-empty flag
  output logic almost_full_flag_n, // almost-full flag
  output logic fall_through_mode // latched timing mode
);
  import sfifo_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int TW = 14;
  localparam int NIN = PI_CTL + DW;
  localparam logic [OFS_W-1:0] DEF_OFS = sfifo_default_ofs(DEPTH);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [TW-1:0] HALF_TH = TW'(DEPTH / 2);
  localparam logic [TW-1:0] DEPTH_T = TW'(DEPTH);
  localparam logic [1:0] FT_LAST = 2'(FT_LATENCY - 1);
  localparam logic [NIN-1:0] IN_IDLE = {{DW{1'b0}}, PIN_IDLE};

  if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two from 256 to 4096");
  end
  if (DW < OFS_W) begin : g_bad_width
    $error("data width must hold an offset");
  end

  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] s3;
    logic [NIN-1:0] filt;
    sfifo_mode_t mode;
    logic syncAlmost;
    logic [CW-1:0] cnt;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic outValid;
    logic [1:0] ftWait;
    logic [DW-1:0] q;
    logic [OFS_W-1:0] emptyOfs;
    logic [OFS_W-1:0] fullOfs;
    sfifo_ofs_sel_t loadSel;
    sfifo_ofs_sel_t readSel;
    logic efN;
    logic ffN;
    logic hfN;
    logic paeN;
    logic pafN;
  } sfifo_state_t;

  sfifo_state_t state_reg;
  sfifo_state_t state_next;
  logic [DW-1:0] mem [DEPTH];
  logic [NIN-1:0] pinsIn;
  logic wEdge;
  logic rEdge;
  logic wenN;
  logic renN;
  logic ldN;
  logic mrstN;
  logic stdM;
  logic ftM;
  logic doWrite;
  logic doLoad;
  logic doRead;
  logic doReadback;
  logic fill;
  logic popMem;
  logic [TW-1:0] tot;
  logic [TW-1:0] aeTh;
  logic [TW-1:0] afTh;
  logic [TW-1:0] hfTh;
  logic [TW-1:0] fullTh;

  assign pinsIn = {data_in, write_expansion_in_n, read_expansion_in_n,
                   first_device_select_n, master_reset_n, offset_load_select_n,
                   read_enable_n, write_enable_n, read_clk, write_clk};

  always_comb begin
    state_next = state_reg;
    state_next.s1 = pinsIn;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // take a pin once the second and third stages agree
    state_next.filt = (state_reg.s2 & state_reg.s3) |
                      (state_reg.filt & (state_reg.s2 | state_reg.s3));
    wEdge = state_next.filt[PI_WCLK] & ~state_reg.filt[PI_WCLK];
    rEdge = state_next.filt[PI_RCLK] & ~state_reg.filt[PI_RCLK];
    wenN = state_next.filt[PI_WEN];
    renN = state_next.filt[PI_REN];
    ldN = state_next.filt[PI_LD];
    mrstN = state_next.filt[PI_MRST];
    stdM = state_reg.mode == SFIFO_MODE_STD;
    ftM = state_reg.mode == SFIFO_MODE_FALL_THROUGH_MODE;
    doWrite = mrstN & wEdge & ~wenN & ldN & (state_reg.cnt != FULL_CNT);
    doLoad = mrstN & wEdge & ~wenN & ~ldN;
    doRead = mrstN & rEdge & ~renN & ldN &
             (stdM ? (state_reg.cnt != '0) : state_reg.outValid);
    doReadback = mrstN & rEdge & ~renN & ~ldN & stdM;
    fill = mrstN & ftM & rEdge & ~state_reg.outValid & (state_reg.cnt != '0) &
           (state_reg.ftWait == FT_LAST);
    popMem = fill | (doRead & (state_reg.cnt != '0));

    if (doWrite) begin
      state_next.wrPtr = state_reg.wrPtr + 1'b1;
    end
    if (popMem) begin
      state_next.q = mem[state_reg.rdPtr];
      state_next.rdPtr = state_reg.rdPtr + 1'b1;
    end
    state_next.cnt = state_reg.cnt + CW'(doWrite) - CW'(popMem);

    // fall-through output register and its three-edge wait
    if (ftM) begin
      if (fill) begin
        state_next.outValid = 1'b1;
        state_next.ftWait = '0;
      end else if (doRead && state_reg.cnt == '0) begin
        state_next.outValid = 1'b0;
      end
      if (!state_reg.outValid && state_reg.cnt != '0 && rEdge && !fill) begin
        state_next.ftWait = state_reg.ftWait + 1'b1;
      end else if (state_reg.outValid || state_reg.cnt == '0) begin
        state_next.ftWait = '0;
      end
    end

    if (doLoad) begin
      if (state_reg.loadSel == SFIFO_OFS_EMPTY) begin
        state_next.emptyOfs = state_next.filt[PI_CTL +: OFS_W];
        state_next.loadSel = SFIFO_OFS_FULL;
      end else begin
        state_next.fullOfs = state_next.filt[PI_CTL +: OFS_W];
        state_next.loadSel = SFIFO_OFS_EMPTY;
      end
    end
    if (doReadback) begin
      state_next.q = '0;
      if (state_reg.readSel == SFIFO_OFS_EMPTY) begin
        state_next.q[OFS_W-1:0] = state_reg.emptyOfs;
        state_next.readSel = SFIFO_OFS_FULL;
      end else begin
        state_next.q[OFS_W-1:0] = state_reg.fullOfs;
        state_next.readSel = SFIFO_OFS_EMPTY;
      end
    end

    // reset operation: straps pick mode and synchronous almost flags, everything else to defaults
    if (!mrstN) begin
      state_next.mode = (!state_next.filt[PI_RXI] && state_next.filt[PI_WXI]) ?
                        SFIFO_MODE_FALL_THROUGH_MODE : SFIFO_MODE_STD;
      state_next.syncAlmost = state_next.filt[PI_FL];
      state_next.cnt = '0;
      state_next.wrPtr = '0;
      state_next.rdPtr = '0;
      state_next.outValid = 1'b0;
      state_next.ftWait = '0;
      state_next.q = '0;
      state_next.emptyOfs = DEF_OFS;
      state_next.fullOfs = DEF_OFS;
      state_next.loadSel = SFIFO_OFS_EMPTY;
      state_next.readSel = SFIFO_OFS_EMPTY;
    end

    // flags from the next count; fall-through counts the output register
    if (state_next.mode == SFIFO_MODE_STD) begin
      tot = TW'(state_next.cnt);
      aeTh = TW'(state_next.emptyOfs);
      hfTh = HALF_TH;
      fullTh = DEPTH_T;
      state_next.efN = state_next.cnt != '0;
    end else begin
      tot = TW'(state_next.cnt) + TW'(state_next.outValid);
      aeTh = TW'(state_next.emptyOfs) + 1'b1;
      hfTh = HALF_TH + 1'b1;
      fullTh = DEPTH_T + 1'b1;
      state_next.efN = ~state_next.outValid;
    end
    afTh = fullTh - TW'(state_next.fullOfs);
    state_next.ffN = (tot == fullTh) ^ (state_next.mode == SFIFO_MODE_STD);
    state_next.hfN = tot <= hfTh;
    if (!mrstN || !state_next.syncAlmost || rEdge) begin
      state_next.paeN = tot > aeTh;
    end
    if (!mrstN || !state_next.syncAlmost || wEdge) begin
      state_next.pafN = tot < afTh;
    end

    if (reset) begin
      state_next = '0;
      // stages start at idle levels so no false pin edge follows reset
      state_next.s1 = IN_IDLE;
      state_next.s2 = IN_IDLE;
      state_next.s3 = IN_IDLE;
      state_next.filt = IN_IDLE;
      state_next.mode = SFIFO_MODE_STD;
      state_next.emptyOfs = DEF_OFS;
      state_next.fullOfs = DEF_OFS;
      state_next.ffN = 1'b1;
      state_next.hfN = 1'b1;
      state_next.pafN = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (!reset && doWrite) begin
      mem[state_reg.wrPtr] <= state_next.filt[PI_CTL +: DW];
    end
  end

  assign data_out = state_reg.q;
  assign empty_flag_n = state_reg.efN;
  assign full_flag_n = state_reg.ffN;
  assign input_ready_n = state_reg.ffN;
  assign half_full_flag_n = state_reg.hfN;
  assign almost_empty_flag_n = state_reg.paeN;
  assign almost_full_flag_n = state_reg.pafN;
  assign fall_through_mode = state_reg.mode == SFIFO_MODE_FALL_THROUGH_MODE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_std_empty_read;
    stdM && state_reg.cnt == '0 && rEdge && !renN && ldN && mrstN && !doWrite;
  endsequence
  sequence s_ft_third_edge;
    ftM && !state_reg.outValid && state_reg.cnt != '0 && state_reg.ftWait == 2'd2 && rEdge;
  endsequence

  chk_std_empty_block: assert property (
    s_std_empty_read |=> $stable(state_reg.q) && !state_reg.efN)
    else $error("read taken from empty buffer");
  chk_ft_first_word: assert property (
    s_ft_third_edge and mrstN |=> state_reg.outValid && !state_reg.efN)
    else $error("first word did not fall through");
  chk_full_write_block: assert property (
    (state_reg.cnt == FULL_CNT && !popMem && mrstN) |=> state_reg.cnt == FULL_CNT)
    else $error("write accepted while full");
  chk_std_half_full: assert property (
    (stdM && state_reg.cnt == CW'(DEPTH / 2 + 1)) |-> !state_reg.hfN)
    else $error("half-full not low above half");
  chk_ft_input_ready: assert property (
    (ftM && state_reg.cnt == FULL_CNT && state_reg.outValid) |-> state_reg.ffN)
    else $error("input ready not high at full capacity");
  chk_load_alternate: assert property (
    doLoad |=> state_reg.loadSel != $past(state_reg.loadSel))
    else $error("offset load sequence did not advance");
  chk_ft_no_readback: assert property (
    (ftM && rEdge && !renN && !ldN && state_reg.outValid && mrstN) |=> $stable(state_reg.q))
    else $error("offset readback in fall-through mode");
  chk_sync_pae_hold: assert property (
    (state_reg.syncAlmost && state_next.syncAlmost && !rEdge && mrstN) |=>
      $stable(state_reg.paeN))
    else $error("synchronous almost-empty moved without read edge");
  chk_reset_offsets: assert property (
    !mrstN |=> state_reg.emptyOfs == DEF_OFS && state_reg.fullOfs == DEF_OFS &&
      state_reg.loadSel == SFIFO_OFS_EMPTY && state_reg.readSel == SFIFO_OFS_EMPTY)
    else $error("reset operation left offsets or pointers");
  chk_write_count: assert property (
    (doWrite && !popMem) |=> state_reg.cnt == $past(state_reg.cnt) + 1'b1)
    else $error("write did not add one word");

  // output register, flag levels and offset pointers between events
  sequence s_offset_read;
    stdM && rEdge && !renN && !ldN && mrstN;
  endsequence

  chk_std_hold_out: assert property (
    (stdM && !popMem && !doReadback && mrstN) |=> $stable(state_reg.q))
    else $error("standard output changed without a read");
  chk_std_almost_empty: assert property (
    (stdM && !state_reg.syncAlmost && TW'(state_reg.cnt) <= TW'(state_reg.emptyOfs)) |->
      !state_reg.paeN)
    else $error("almost-empty high at or below offset");
  chk_std_full_flag: assert property (
    (stdM && state_reg.cnt == FULL_CNT) |-> !state_reg.ffN)
    else $error("full flag not low at depth");
  chk_ft_ready_empty: assert property (
    (ftM && !state_reg.outValid) |-> state_reg.efN)
    else $error("output ready low with no word shown");
  chk_ft_half_full: assert property (
    (ftM && state_reg.outValid && state_reg.cnt == CW'(DEPTH / 2 + 1)) |-> !state_reg.hfN)
    else $error("fall-through half-full not low above half plus one");
  chk_load_keep_seq: assert property (
    (!doLoad && mrstN) |=> $stable(state_reg.loadSel))
    else $error("offset load position moved without a load");
  chk_readback_step: assert property (
    s_offset_read |=> state_reg.readSel != $past(state_reg.readSel))
    else $error("offset readback sequence did not advance");
  chk_sync_paf_hold: assert property (
    (state_reg.syncAlmost && state_next.syncAlmost && !wEdge && mrstN) |=>
      $stable(state_reg.pafN))
    else $error("synchronous almost-full moved without write edge");
endmodule // sfifo_core

// >>> core/sfifo_pkg.sv
// Purpose: shared constants for the two-mode flagged buffer core
// Assumes: pins are sampled on one system clock
// Notes: pin vector indices give the order of the sampled pin bundle
package sfifo_pkg;
  localparam int DATA_W_DEF = 18;
  localparam int DEPTH_DEF = 256;
  localparam int DEPTH_MIN = 256;
  localparam int DEPTH_MAX = 4096;
  localparam int OFS_W = 12;
  localparam int FT_LATENCY = 3;
  localparam int SYNC_STAGES = 3;
  localparam logic [OFS_W-1:0] DEF_OFS_256 = 12'h01F;
  localparam logic [OFS_W-1:0] DEF_OFS_512 = 12'h03F;
  localparam logic [OFS_W-1:0] DEF_OFS_BIG = 12'h07F;
  // pin bundle bit positions
  localparam int PI_WCLK = 0;
  localparam int PI_RCLK = 1;
  localparam int PI_WEN = 2;
  localparam int PI_REN = 3;
  localparam int PI_LD = 4;
  localparam int PI_MRST = 5;
  localparam int PI_FL = 6;
  localparam int PI_RXI = 7;
  localparam int PI_WXI = 8;
  localparam int PI_CTL = 9;
  // clocks low, active-low controls idle high
  localparam logic [PI_CTL-1:0] PIN_IDLE = 9'h1FC;

  typedef enum logic {
    SFIFO_MODE_STD = 1'b0,
    SFIFO_MODE_FALL_THROUGH_MODE = 1'b1
  } sfifo_mode_t;

  typedef enum logic {
    SFIFO_OFS_EMPTY = 1'b0,
    SFIFO_OFS_FULL = 1'b1
  } sfifo_ofs_sel_t;

  function automatic logic [OFS_W-1:0] sfifo_default_ofs(input int depth);
    if (depth == 256) begin
      return DEF_OFS_256;
    end else if (depth == 512) begin
      return DEF_OFS_512;
    end
    return DEF_OFS_BIG;
  endfunction
endpackage

// >>> bench/sfifo_pins.sv
// Purpose: writer and reader pin model facing the buffer core
// Assumes: tasks entered at a clk rise
// Notes: wr and rd set controls 1 clk before the clock pin rises, clock levels held 5 clk, data shows inverse word when released
`timescale 1ns/1ns
module sfifo_pins #(
  parameter int DW = sfifo_pkg::DATA_W_DEF // data width
) (
  input wire logic clk, // system clock
  output logic wClk, // write clock pin
  output logic rClk, // read clock pin
  output logic wenN, // write enable
  output logic renN, // read enable
  output logic ldN, // offset select
  output logic mrstN, // reset operation
  output logic [2:0] strapN, // first, read, write straps
  output logic [DW-1:0] din // write data
);
  initial begin
    {wClk, rClk} = 2'h0;
    {wenN, renN, ldN, mrstN} = 4'hF;
    strapN = 3'h0;
    din = {DW{1'b0}};
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic mreset(input logic [2:0] s);
    mrstN <= 1'b0;
    strapN <= s;
    hold(8);
    mrstN <= 1'b1;
    hold(8);
  endtask
  task automatic wr(input logic ld, input logic [DW-1:0] d);
    wenN <= 1'b0;
    ldN <= ld;
    din <= d;
    hold(1);
    wClk <= 1'b1;
    hold(5);
    {wClk, wenN, ldN} <= 3'h3;
    din <= ~d;
    hold(5);
  endtask
  task automatic rd(input logic ld, input logic ren);
    renN <= ren;
    ldN <= ld;
    hold(1);
    rClk <= 1'b1;
    hold(5);
    {rClk, renN, ldN} <= 3'h3;
    hold(5);
  endtask
endmodule // sfifo_pins

// >>> bench/test_sync_fifo_modes_flags_offsets.sv
// Purpose: self-checking bench for the two-mode flagged buffer core
// Assumes: depth 256, default offsets 31
// Notes: flag rows are full or input-ready, almost-full, half, almost-empty, empty
`timescale 1ns/1ns
module test_sync_fifo_modes_flags_offsets;
  localparam int DW = 18;
  typedef struct packed {
    logic ft;
    logic [8:0] cnt;
    logic [4:0] exp;
  } sfifo_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wClk, rClk, wenN, renN, ldN, mrstN;
  logic [2:0] strapN;
  logic [DW-1:0] din, dataOut;
  logic emptyN, fullN, irN, halfN, aeN, afN, ftMode;
  int failCount = 0;
  int checkCount = 0;
  int cnt;
  sfifo_row_t rows [18];
  always #4 clk = ~clk;
  sfifo_pins #(.DW(DW)) u_sfifo_pins (.clk(clk), .wClk(wClk), .rClk(rClk),
    .wenN(wenN), .renN(renN), .ldN(ldN), .mrstN(mrstN), .strapN(strapN), .din(din));
  sfifo_core #(.DW(DW), .DEPTH(256)) u_sfifo_core (.clk(clk), .reset(reset),
    .write_clk(wClk), .read_clk(rClk), .write_enable_n(wenN), .read_enable_n(renN),
    .offset_load_select_n(ldN), .master_reset_n(mrstN),
    .first_device_select_n(strapN[2]), .read_expansion_in_n(strapN[1]),
    .write_expansion_in_n(strapN[0]), .data_in(din), .data_out(dataOut),
    .empty_flag_n(emptyN), .full_flag_n(fullN), .input_ready_n(irN),
    .half_full_flag_n(halfN), .almost_empty_flag_n(aeN), .almost_full_flag_n(afN),
    .fall_through_mode(ftMode));
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict();
    if (failCount == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #240000;
    failCount++;
    giveVerdict();
  end
  initial begin
    rows = '{'{1'b1, 9'h000, 5'h0D}, '{1'b1, 9'h001, 5'h0C},
      '{1'b1, 9'h020, 5'h0C}, '{1'b1, 9'h021, 5'h0E},
      '{1'b1, 9'h081, 5'h0E}, '{1'b1, 9'h082, 5'h0A},
      '{1'b1, 9'h0E1, 5'h0A}, '{1'b1, 9'h0E2, 5'h02},
      '{1'b1, 9'h101, 5'h12},
      '{1'b0, 9'h000, 5'h1C}, '{1'b0, 9'h001, 5'h1D},
      '{1'b0, 9'h01F, 5'h1D}, '{1'b0, 9'h020, 5'h1F},
      '{1'b0, 9'h080, 5'h1F}, '{1'b0, 9'h081, 5'h1B},
      '{1'b0, 9'h0E0, 5'h1B}, '{1'b0, 9'h0E1, 5'h13},
      '{1'b0, 9'h100, 5'h03}};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    cnt = 0;
    for (int i = 0; i < 18; i++) begin
      if (rows[i].cnt == 9'h000) begin
        u_sfifo_pins.mreset({2'h0, rows[i].ft});
        cnt = 0;
      end
      while (cnt < int'(rows[i].cnt)) begin
        u_sfifo_pins.wr(1'b1, DW'(cnt + 1));
        if (rows[i].ft && cnt == 0) begin
          u_sfifo_pins.rd(1'b1, 1'b1);
          u_sfifo_pins.rd(1'b1, 1'b1);
          check(DW'(emptyN), DW'(1'b1));
          u_sfifo_pins.rd(1'b1, 1'b1);
          check(dataOut, DW'(1));
        end
        cnt++;
      end
      check(DW'(ftMode), DW'(rows[i].ft));
      check(DW'({rows[i].ft ? irN : fullN, afN, halfN, aeN, emptyN}), DW'(rows[i].exp));
    end
    // full standard buffer: overflow word must never come out
    u_sfifo_pins.wr(1'b1, 18'h3FFFF);
    check(DW'(fullN), DW'(1'b0));
    for (int k = 1; k <= 256; k++) begin
      u_sfifo_pins.rd(1'b1, 1'b0);
      check(dataOut, DW'(k));
      if (k == 1) begin
        check(DW'(fullN), DW'(1'b1));
      end
    end
    check(DW'(emptyN), DW'(1'b0));
    u_sfifo_pins.rd(1'b1, 1'b0);
    check(dataOut, DW'(256));
    u_sfifo_pins.wr(1'b1, 18'h2AAAA);
    check(dataOut, DW'(256));
    u_sfifo_pins.rd(1'b1, 1'b0);
    check(dataOut, 18'h2AAAA);
    // offsets: empty 5, full 7, empty 9, a data word, then full 10
    u_sfifo_pins.mreset(3'h0);
    u_sfifo_pins.wr(1'b0, 18'h00005);
    u_sfifo_pins.wr(1'b0, 18'h00007);
    u_sfifo_pins.wr(1'b0, 18'h3F009);
    u_sfifo_pins.wr(1'b1, 18'h00001);
    u_sfifo_pins.wr(1'b0, 18'h0000A);
    u_sfifo_pins.rd(1'b0, 1'b0);
    check(dataOut, 18'h00009);
    u_sfifo_pins.rd(1'b0, 1'b0);
    check(dataOut, 18'h0000A);
    repeat (8) u_sfifo_pins.wr(1'b1, 18'h00001);
    check(DW'(aeN), DW'(1'b0));
    u_sfifo_pins.wr(1'b1, 18'h00001);
    check(DW'(aeN), DW'(1'b1));
    u_sfifo_pins.mreset(3'h0);
    repeat (2) begin
      u_sfifo_pins.rd(1'b0, 1'b0);
      check(dataOut, 18'h0001F);
    end
    // synchronous almost-empty moves only on a read clock edge; fall-through blocks offset readback
    u_sfifo_pins.mreset(3'h4);
    check(DW'(ftMode), DW'(1'b0));
    u_sfifo_pins.wr(1'b0, 18'h00002);
    repeat (3) u_sfifo_pins.wr(1'b1, 18'h00001);
    check(DW'(aeN), DW'(1'b0));
    u_sfifo_pins.rd(1'b1, 1'b1);
    check(DW'(aeN), DW'(1'b1));
    u_sfifo_pins.mreset(3'h1);
    u_sfifo_pins.wr(1'b1, 18'h12345);
    repeat (3) u_sfifo_pins.rd(1'b1, 1'b1);
    u_sfifo_pins.rd(1'b0, 1'b0);
    check(dataOut, 18'h12345);
    giveVerdict();
  end
endmodule // test_sync_fifo_modes_flags_offsets
